// ===== host_pins_pkg.sv
// Shared constants and types for the host select and trigger block
package host_pins_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] ADDR_CFG1 = 12'h000;
	localparam logic [11:0] ADDR_MODE = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;

	// Configuration register 1 fields and reset values
	localparam int unsigned CFG_SSF_BIT       = 8;
	localparam int unsigned CFG_TRIG_EN_BIT   = 7;
	localparam logic        CFG_SSF_RESET     = 1'b1;
	localparam logic        CFG_TRIG_EN_RESET = 1'b0;

	// Status register fields
	localparam int unsigned STAT_SSF_BIT    = 0;
	localparam int unsigned STAT_TRANSP_BIT = 1;
	localparam int unsigned STAT_BUS16_BIT  = 2;
	localparam int unsigned STAT_WAIT_BIT   = 3;
	localparam int unsigned STAT_CNT_LSB    = 8;
	localparam int unsigned CNT_W           = 8;

	// ==========================================================
	// Pin vector layout and idle levels used at reset
	localparam int unsigned PIN_RAM_SEL_N = 0;
	localparam int unsigned PIN_MEM_SEL   = 1;
	localparam int unsigned PIN_SSF_N     = 2;
	localparam int unsigned PIN_TRIG      = 3;
	localparam int unsigned PIN_GRANT_N   = 4;
	localparam int unsigned PIN_STROBE_N  = 5;
	localparam int unsigned PIN_BUS16     = 6;
	localparam int unsigned PIN_STRAP     = 7;
	localparam int unsigned PIN_W         = 8;
	localparam logic [7:0]  PINS_IDLE     = 8'h35;

	// ==========================================================
	// Operating modes and wait-for-trigger states
	typedef enum logic [2:0] {
		MODE_RT   = 3'h0,
		MODE_BC   = 3'h1,
		MODE_EBC  = 3'h2,
		MODE_WMON = 3'h3,
		MODE_MMON = 3'h4
	} mode_t;
	localparam mode_t MODE_RESET = MODE_RT;

	typedef enum logic [1:0] {
		WT_IDLE = 2'b01,
		WT_WAIT = 2'b10
	} wait_state_t;

endpackage

// ===== pin_sync_if.sv
// Synchronised host pin levels passed between the block's modules
`timescale 1ns/100ps
interface pin_sync_if;
	logic ram_sel_n;
	logic mem_sel;
	logic subsystem_flag_in_n_n;
	logic trig_rise;
	logic grant_n;
	logic strobe_n;
	logic bus16;
	logic transparent;

	modport sync_side (
		output ram_sel_n, mem_sel, subsystem_flag_in_n_n, trig_rise,
		output grant_n, strobe_n, bus16, transparent
	);
	modport user_side (
		input ram_sel_n, mem_sel, subsystem_flag_in_n_n, trig_rise,
		input grant_n, strobe_n, bus16, transparent
	);
endinterface

// ===== pin_sync.sv
// Two-stage pin synchroniser with trigger rising edge detect
`timescale 1ns/100ps
module pin_sync
	import host_pins_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	// Raw pins packed by layout
	input  wire logic [PIN_W-1:0] pins,
	// Synchronised levels
	pin_sync_if.sync_side         sy
);

	typedef struct packed {
		logic [PIN_W-1:0] meta;
		logic [PIN_W-1:0] sync;
		logic             trig_last;
		logic             rise;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// ==========================================================
	// Next state: first stage feeds only the second
	always_comb begin
		next_st           = st;
		next_st.meta      = pins;
		next_st.sync      = st.meta;
		next_st.trig_last = st.sync[PIN_TRIG];
		next_st.rise      = st.sync[PIN_TRIG] & ~st.trig_last;
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st <= '{meta: PINS_IDLE, sync: PINS_IDLE,
				trig_last: 1'b0, rise: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs to the consumers
	assign sy.ram_sel_n   = st.sync[PIN_RAM_SEL_N];
	assign sy.mem_sel     = st.sync[PIN_MEM_SEL];
	assign sy.subsystem_flag_in_n_n    = st.sync[PIN_SSF_N];
	assign sy.grant_n     = st.sync[PIN_GRANT_N];
	assign sy.strobe_n    = st.sync[PIN_STROBE_N];
	assign sy.bus16       = st.sync[PIN_BUS16];
	assign sy.transparent = st.sync[PIN_STRAP];
	assign sy.trig_rise   = st.rise;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_rise_single_pulse: assert property (
		st.rise |=> !st.rise)
		else $error("trigger rise lasted more than one cycle");
	a_rise_from_edge: assert property (
		(!st.sync[PIN_TRIG] ##1 st.sync[PIN_TRIG]) |=> st.rise)
		else $error("low then high trigger sample gave no pulse");

endmodule

// ===== host_access_decode.sv
// Host access routing by interface mode, select pins and grant
`timescale 1ns/100ps
module host_access_decode
	import host_pins_pkg::*;
(
	// Clock and reset
	input  wire logic     clk_sys,
	input  wire logic     nrst,
	// Synchronised pins
	pin_sync_if.user_side sy,
	// Routed access
	output logic          shared_ram_cs,
	output logic          byte_msb_first,
	output logic          mem_access,
	output logic          reg_access,
	output logic          bus_accept_n
);

	typedef struct packed {
		logic ram_cs;
		logic msb_first;
		logic mem_acc;
		logic reg_acc;
		logic accept_n;
	} dec_state_t;

	dec_state_t st;
	dec_state_t next_st;
	logic       strobe;
	logic       buf8;
	logic       buf16;

	// Interface mode from the strap and width pin
	assign strobe = ~sy.strobe_n;
	assign buf8   = ~sy.transparent & ~sy.bus16;
	assign buf16  = ~sy.transparent & sy.bus16;

	// ==========================================================
	// Next routing decision
	always_comb begin
		next_st          = st;
		next_st.accept_n = ~(sy.transparent & ~sy.grant_n);
		next_st.ram_cs   = sy.transparent & ~sy.ram_sel_n;
		// Shared pin is byte order only in 8-bit buffered mode
		next_st.msb_first = buf8 ? sy.ram_sel_n : 1'b1;
		next_st.mem_acc  = strobe & sy.mem_sel
			& (sy.transparent ? ~sy.ram_sel_n : 1'b1);
		next_st.reg_acc  = strobe & ~sy.mem_sel;
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st <= '{ram_cs: 1'b0, msb_first: 1'b1, mem_acc: 1'b0,
				reg_acc: 1'b0, accept_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign shared_ram_cs  = st.ram_cs;
	assign byte_msb_first = st.msb_first;
	assign mem_access     = st.mem_acc;
	assign reg_access     = st.reg_acc;
	assign bus_accept_n   = st.accept_n;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_buf16_ignore_sel: assert property (
		(buf16 && strobe && sy.mem_sel) |=> (mem_access && byte_msb_first))
		else $error("select pin changed a 16-bit buffered access");
	a_ram_cs_gate: assert property (
		(sy.transparent && strobe && sy.mem_sel && sy.ram_sel_n)
		|=> (!mem_access && !shared_ram_cs))
		else $error("RAM access without chip select");
	a_reg_route: assert property (
		(strobe && !sy.mem_sel) |=> (reg_access && !mem_access))
		else $error("low select did not route to registers");
	a_accept_frame: assert property (
		!bus_accept_n |-> $past(sy.transparent && !sy.grant_n))
		else $error("bus accept without grant in transparent mode");

endmodule

// ===== host_select_trigger.sv
// Host select pins, subsystem flag and external trigger handling
// Contract
// - 16-bit buffered mode ignores the shared RAM select pin.
// - Transparent mode uses that pin as an active-low RAM select.
// - Memory select high routes to memory, low to registers.
// - In RT mode a low flag pin sets the status word flag bit.
// - The config flag bit reads back as written, whatever the pin.
// - Plain BC mode with trigger enabled starts a frame on a rise.
// - Enhanced BC waiting on a trigger proceeds on the next rise.
// - Word monitor with trigger enabled starts monitoring on a rise.
// - Message monitor mode ignores the trigger input.
// - A static strap picks buffered (low) or transparent (high).
// - In 8-bit buffered mode the shared pin picks the byte order.
// - Transparent mode drives bus accept low to take a granted bus.
`timescale 1ns/100ps
module host_select_trigger
	import host_pins_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Host pins
	input  wire logic        shared_ram_select_n,
	input  wire logic        mem_select,
	input  wire logic        subsystem_flag_in_n,
	input  wire logic        external_trigger_in,
	input  wire logic        bus_grant_n,
	input  wire logic        host_strobe_n,
	input  wire logic        bus_width_16,
	input  wire logic        transparent_strap,
	output logic             bus_accept_n,
	// Access routing
	output logic             shared_ram_cs,
	output logic             byte_msb_first,
	output logic             mem_access,
	output logic             reg_access,
	// Protocol engine side
	input  wire logic        wait_trigger_instruction,
	output logic             bc_start,
	output logic             wtg_proceed,
	output logic             monitor_start,
	output logic             waiting_trigger,
	output logic             rt_status_subsystem_flag_in_n
);

	typedef struct packed {
		logic             cfg_ssf_n;
		logic             cfg_trig_en;
		mode_t            mode;
		wait_state_t      wst;
		logic [CNT_W-1:0] trig_count;
		logic [31:0]      rdata;
		logic             slverr;
		logic             bc_start;
		logic             wtg_proceed;
		logic             mon_start;
		logic             rt_ssf;
	} top_state_t;

	top_state_t       st;
	top_state_t       next_st;
	logic [PIN_W-1:0] pins;
	logic             apb_setup;
	logic             apb_write;
	logic             rise;

	pin_sync_if sy ();

	// ==========================================================
	// Pin synchroniser and access decoder
	assign pins = {transparent_strap, bus_width_16, host_strobe_n,
		bus_grant_n, external_trigger_in, subsystem_flag_in_n,
		mem_select, shared_ram_select_n};

	pin_sync u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pins    (pins),
		.sy      (sy.sync_side)
	);

	host_access_decode u_dec (
		.clk_sys        (clk_sys),
		.nrst           (nrst),
		.sy             (sy.user_side),
		.shared_ram_cs  (shared_ram_cs),
		.byte_msb_first (byte_msb_first),
		.mem_access     (mem_access),
		.reg_access     (reg_access),
		.bus_accept_n   (bus_accept_n)
	);

	// ==========================================================
	// Register access helpers

	// Whether an address is a mapped register
	function automatic logic addr_known(input logic [11:0] a);
		return (a == ADDR_CFG1) || (a == ADDR_MODE)
			|| (a == ADDR_STAT);
	endfunction

	// Read word for an address
	function automatic logic [31:0] read_word(input logic [11:0] a,
		input top_state_t s, input logic transp, input logic b16);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			ADDR_CFG1: begin
				w[CFG_SSF_BIT]     = s.cfg_ssf_n;
				w[CFG_TRIG_EN_BIT] = s.cfg_trig_en;
			end
			ADDR_MODE: begin
				w[2:0] = s.mode;
			end
			ADDR_STAT: begin
				w[STAT_SSF_BIT]    = s.rt_ssf;
				w[STAT_TRANSP_BIT] = transp;
				w[STAT_BUS16_BIT]  = b16;
				w[STAT_WAIT_BIT]   = (s.wst == WT_WAIT);
				w[STAT_CNT_LSB +: CNT_W] = s.trig_count;
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// APB phase decode; pready is tied high, so every transfer ends
	// in its first access cycle and a write commits at that edge
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite & addr_known(paddr);
	assign rise      = sy.trig_rise;

	// ==========================================================
	// Next state
	always_comb begin
		next_st             = st;
		next_st.bc_start    = 1'b0;
		next_st.wtg_proceed = 1'b0;
		next_st.mon_start   = 1'b0;

		// Read data and error latched in the setup cycle
		if (apb_setup) begin
			next_st.rdata  = read_word(paddr, st, sy.transparent,
				sy.bus16);
			next_st.slverr = ~addr_known(paddr);
		end

		// Writes take effect at the access edge
		if (apb_write) begin
			case (paddr)
				ADDR_CFG1: begin
					next_st.cfg_ssf_n   = pwdata[CFG_SSF_BIT];
					next_st.cfg_trig_en = pwdata[CFG_TRIG_EN_BIT];
				end
				ADDR_MODE: begin
					case (pwdata[2:0])
						MODE_RT, MODE_BC, MODE_EBC, MODE_WMON,
						MODE_MMON: begin
							next_st.mode = mode_t'(pwdata[2:0]);
						end
						default: begin
							next_st.mode = st.mode;
						end
					endcase
				end
				default: begin
					next_st.mode = st.mode;
				end
			endcase
		end

		// Trigger dispatch by mode; message monitor takes none
		// The rise pulse lasts one cycle, so each start pulse does too
		if (rise && st.mode != MODE_MMON) begin
			next_st.trig_count = st.trig_count + 8'h01;
		end
		next_st.bc_start  = (st.mode == MODE_BC)
			& st.cfg_trig_en & rise;
		next_st.mon_start = (st.mode == MODE_WMON)
			& st.cfg_trig_en & rise;

		// Wait for external trigger instruction
		case (st.wst)
			WT_IDLE: begin
				if (st.mode == MODE_EBC && wait_trigger_instruction) begin
					next_st.wst = WT_WAIT;
				end
			end
			WT_WAIT: begin
				if (st.mode != MODE_EBC) begin
					next_st.wst = WT_IDLE;
				end else if (rise) begin
					next_st.wst         = WT_IDLE;
					next_st.wtg_proceed = 1'b1;
				end
			end
			default: begin
				next_st.wst = WT_IDLE;
			end
		endcase

		// Status word flag from register bit or pin
		next_st.rt_ssf = (st.mode == MODE_RT)
			& (~st.cfg_ssf_n | ~sy.subsystem_flag_in_n_n);
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st <= '{cfg_ssf_n: CFG_SSF_RESET,
				cfg_trig_en: CFG_TRIG_EN_RESET,
				mode: MODE_RESET, wst: WT_IDLE,
				trig_count: 8'h00, rdata: 32'h0000_0000,
				slverr: 1'b0, bc_start: 1'b0, wtg_proceed: 1'b0,
				mon_start: 1'b0, rt_ssf: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	// Error shows only in the access phase, so a stale error from
	// an earlier setup never reaches an idle bus
	assign prdata           = st.rdata;
	assign pready           = 1'b1;
	assign pslverr          = psel & penable & st.slverr;
	assign bc_start         = st.bc_start;
	assign wtg_proceed      = st.wtg_proceed;
	assign monitor_start    = st.mon_start;
	assign waiting_trigger  = (st.wst == WT_WAIT);
	assign rt_status_subsystem_flag_in_n = st.rt_ssf;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_subsystem_flag_in_n_status: assert property (
		(st.mode == MODE_RT && !sy.subsystem_flag_in_n_n) |=> rt_status_subsystem_flag_in_n)
		else $error("low flag pin did not set status flag");
	a_cfg_readback: assert property (
		(apb_setup && !pwrite && paddr == ADDR_CFG1)
		|=> prdata[CFG_SSF_BIT] == $past(st.cfg_ssf_n))
		else $error("flag bit read back differs from register");
	a_subsystem_flag_in_n_reg_stable: assert property (
		(!apb_write && $changed(sy.subsystem_flag_in_n_n))
		|=> $stable(st.cfg_ssf_n))
		else $error("flag pin altered the config flag bit");
	a_bc_start_cause: assert property (
		(st.mode == MODE_BC && st.cfg_trig_en && rise) |=> bc_start)
		else $error("enabled trigger rise gave no frame start");
	a_bc_start_only: assert property (
		bc_start |-> $past(st.mode == MODE_BC && st.cfg_trig_en && rise))
		else $error("frame start without enabled trigger rise");
	a_wtg_stall: assert property (
		(waiting_trigger && !rise) |=> (!wtg_proceed && waiting_trigger)
		or (!wtg_proceed && $past(st.mode) != MODE_EBC))
		else $error("wait for trigger left without a rise");
	a_wtg_proceed: assert property (
		(waiting_trigger && st.mode == MODE_EBC && rise)
		|=> (wtg_proceed && !waiting_trigger))
		else $error("trigger rise did not end the wait");
	a_mon_start: assert property (
		(st.mode == MODE_WMON && st.cfg_trig_en && rise)
		|=> monitor_start ##1 !monitor_start)
		else $error("monitor start missing or not one cycle");
	a_msgmon_quiet: assert property (
		(bc_start || monitor_start || wtg_proceed)
		|-> $past(st.mode) != MODE_MMON)
		else $error("trigger acted in message monitor mode");

	// Trigger gating by enable bit and by mode
	a_bc_gated_off: assert property (
		!st.cfg_trig_en |=> (!bc_start && !monitor_start))
		else $error("trigger start while external start disabled");
	a_msgmon_no_count: assert property (
		(st.mode == MODE_MMON && rise) |=> $stable(st.trig_count))
		else $error("trigger counted in message monitor mode");
	a_mon_mode_only: assert property (
		monitor_start |-> $past(st.mode == MODE_WMON))
		else $error("monitor start outside word monitor mode");

	// Wait entry and status flag outside RT mode
	a_wtg_enter: assert property (
		(!waiting_trigger && st.mode == MODE_EBC
			&& wait_trigger_instruction) |=> waiting_trigger)
		else $error("wait instruction did not start the wait");
	a_subsystem_flag_in_n_rt_only: assert property (
		(st.mode != MODE_RT) |=> !rt_status_subsystem_flag_in_n)
		else $error("status flag set outside RT mode");

	c_bc_start:   cover property (bc_start);
	c_wtg_done:   cover property (waiting_trigger ##1 wtg_proceed);
	c_mon_start:  cover property (monitor_start);
	c_cfg_write:  cover property (apb_write && paddr == ADDR_CFG1);
	c_subsystem_flag_in_n:     cover property (rt_status_subsystem_flag_in_n);

endmodule

// ===== host_glue_model.sv
// Host side glue model driving the shared RAM select pin
`timescale 1ns/100ps
module host_glue_model (
	// Control from the bench
	input  wire logic glue_en,
	input  wire logic ram_sel_cmd_n,
	// Device outputs and host strobe
	input  wire logic bus_accept_n,
	input  wire logic host_strobe_n,
	// Pin towards the device
	output logic      shared_ram_select_n
);
	// ==========================================================
	// Select glue
	// Strobe stands in for the access-active output, which this
	// block does not have; otherwise the bench drives the pin
	always_comb begin
		if (glue_en)
			shared_ram_select_n = bus_accept_n | host_strobe_n;
		else
			shared_ram_select_n = ram_sel_cmd_n;
	end
endmodule

// ===== host_select_trigger_tb.sv
// Self-checking bench for the host select and trigger block
`timescale 1ns/100ps
module host_select_trigger_tb
	import host_pins_pkg::*;
;

	// ==========================================================
	// Signals
	logic        clk_sys = 0, nrst = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr;
	logic        ram_sel_n, mem_sel = 0, ssf_n = 1, trig = 0;
	logic        grant_n = 1, strobe_n = 1, bus16 = 0, strap = 0;
	logic        glue_en = 0, ram_cmd_n = 1, wti = 0;
	logic        bus_accept_n, ram_cs, msb_first, mem_acc, reg_acc;
	logic        bc_start, wtg_proceed, mon_start, waiting, rt_ssf;
	int          n_mismatch = 0, checked = 0;
	int          n_bc = 0, n_mon = 0, n_wtg = 0;
	logic [31:0] q;
	logic        err;

	always #20 clk_sys = ~clk_sys;

	// Pulse tallies
	always @(posedge clk_sys) begin
		if (bc_start === 1'b1) n_bc++;
		if (mon_start === 1'b1) n_mon++;
		if (wtg_proceed === 1'b1) n_wtg++;
	end

	host_glue_model u_glue (
		.glue_en            (glue_en),
		.ram_sel_cmd_n      (ram_cmd_n),
		.bus_accept_n       (bus_accept_n),
		.host_strobe_n      (strobe_n),
		.shared_ram_select_n(ram_sel_n)
	);

	host_select_trigger u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.shared_ram_select_n(ram_sel_n), .mem_select(mem_sel),
		.subsystem_flag_in_n(ssf_n), .external_trigger_in(trig),
		.bus_grant_n(grant_n), .host_strobe_n(strobe_n),
		.bus_width_16(bus16), .transparent_strap(strap),
		.bus_accept_n(bus_accept_n), .shared_ram_cs(ram_cs),
		.byte_msb_first(msb_first), .mem_access(mem_acc),
		.reg_access(reg_acc), .wait_trigger_instruction(wti),
		.bc_start(bc_start), .wtg_proceed(wtg_proceed),
		.monitor_start(mon_start), .waiting_trigger(waiting),
		.rt_status_subsystem_flag_in_n(rt_ssf)
	);

	// ==========================================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		q = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task automatic rise;
		@(posedge clk_sys);
		trig <= 1;
		cyc(4);
		trig <= 0;
		cyc(8);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_regs;
		apb(0, ADDR_CFG1, 0); chk("cfg1 reset", 32'h00000100, q);
		chk("cfg1 err", 32'h0, {31'h0, err});
		apb(0, ADDR_MODE, 0); chk("mode reset", 32'h00000000, q);
		apb(1, ADDR_MODE, 32'h7);
		apb(0, ADDR_MODE, 0);
		chk("mode refused", 32'h0, q);
		apb(1, 12'h0fc, 32'hffffffff);
		chk("unmapped err", 32'h1, {31'h0, err});
		$display("test regs done");
	endtask

	task automatic test_subsystem_flag_in_n;
		@(posedge clk_sys) ssf_n <= 0;
		cyc(8); chk("status flag pin", 32'h1, {31'h0, rt_ssf});
		apb(0, ADDR_CFG1, 0); chk("cfg1 pin low", 32'h100, q);
		apb(1, ADDR_MODE, 32'h1); cyc(2);
		chk("flag outside rt", 32'h0, {31'h0, rt_ssf});
		apb(1, ADDR_MODE, 32'h0);
		@(posedge clk_sys) ssf_n <= 1;
		apb(1, ADDR_CFG1, 32'h0); cyc(8);
		chk("flag by software", 32'h1, {31'h0, rt_ssf});
		apb(0, ADDR_CFG1, 0); chk("cfg1 cleared", 32'h0, q);
		apb(1, ADDR_CFG1, 32'h100); cyc(2);
		chk("flag released", 32'h0, {31'h0, rt_ssf});
		$display("test subsystem_flag_in_n done");
	endtask

	task automatic test_bc;
		int b;
		b = n_bc;
		apb(1, ADDR_MODE, 32'h1);
		rise; chk("bc start off", b, n_bc);
		apb(1, ADDR_CFG1, 32'h180);
		rise; chk("bc start on", b + 1, n_bc);
		rise; chk("bc start again", b + 2, n_bc);
		$display("test bc done");
	endtask

	task automatic test_monitors;
		int m, b;
		logic [31:0] s0;
		m = n_mon;
		b = n_bc;
		apb(1, ADDR_MODE, 32'h3);
		rise; chk("word monitor start", m + 1, n_mon);
		apb(1, ADDR_MODE, 32'h4);
		apb(0, ADDR_STAT, 0); s0 = q;
		rise; chk("msg monitor start", m + 1, n_mon);
		chk("msg monitor bc", b, n_bc);
		apb(0, ADDR_STAT, 0);
		chk("msg monitor count", s0[15:8], q[15:8]);
		$display("test monitors done");
	endtask

	task automatic test_ebc;
		int w;
		w = n_wtg;
		apb(1, ADDR_MODE, 32'h2);
		@(posedge clk_sys) wti <= 1;
		@(posedge clk_sys) wti <= 0;
		cyc(12); chk("waiting set", 32'h1, {31'h0, waiting});
		chk("no early proceed", w, n_wtg);
		apb(0, ADDR_STAT, 0); chk("stat waiting", 32'h1, {31'h0, q[3]});
		rise; chk("proceed", w + 1, n_wtg);
		chk("waiting clear", 32'h0, {31'h0, waiting});
		$display("test ebc done");
	endtask

	task automatic test_routing;
		@(posedge clk_sys);
		strap <= 1; grant_n <= 0; glue_en <= 1;
		mem_sel <= 1; strobe_n <= 0;
		cyc(12);
		chk("accept low", 32'h0, {31'h0, bus_accept_n});
		chk("ram cs", 32'h1, {31'h0, ram_cs});
		chk("mem access", 32'h1, {31'h0, mem_acc});
		@(posedge clk_sys) glue_en <= 0;
		cyc(8); chk("mem gated", 32'h0, {31'h0, mem_acc});
		@(posedge clk_sys) mem_sel <= 0;
		cyc(8); chk("reg access", 32'h1, {31'h0, reg_acc});
		@(posedge clk_sys) grant_n <= 1;
		cyc(8); chk("accept high", 32'h1, {31'h0, bus_accept_n});
		@(posedge clk_sys);
		strap <= 0; bus16 <= 1; mem_sel <= 1; ram_cmd_n <= 1;
		cyc(8); chk("16 bit mem", 32'h1, {31'h0, mem_acc});
		chk("16 bit reg", 32'h0, {31'h0, reg_acc});
		chk("buffered accept", 32'h1, {31'h0, bus_accept_n});
		apb(0, ADDR_STAT, 0);
		chk("stat strap bus16", 32'h4, {29'h0, q[2:0]});
		@(posedge clk_sys) ram_cmd_n <= 0;
		cyc(8);
		chk("16 bit sel ignored", 32'h1, {31'h0, mem_acc});
		chk("16 bit order", 32'h1, {31'h0, msb_first});
		@(posedge clk_sys) ram_cmd_n <= 1;
		@(posedge clk_sys) bus16 <= 0;
		cyc(8); chk("msb first", 32'h1, {31'h0, msb_first});
		@(posedge clk_sys) ram_cmd_n <= 0;
		cyc(8); chk("lsb first", 32'h0, {31'h0, msb_first});
		@(posedge clk_sys) strobe_n <= 1;
		$display("test routing done");
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		cyc(20000);
		n_mismatch++;
		conclude;
	end

	// Main sequence
	initial begin
		cyc(5);
		nrst <= 1;
		cyc(4);
		test_regs;
		test_subsystem_flag_in_n;
		test_bc;
		test_monitors;
		test_ebc;
		test_routing;
		conclude;
	end
endmodule
